// ---- design/irq_cmd_pkg.sv ----
// shared constants and types of the interrupt and error-flag command block
package irq_cmd_pkg;
  localparam int IRQ_N = 32;
  localparam int NFLAG = 5;
  localparam int NEV = 5;
  // instruction codes
  localparam logic [7:0] OP_CLEAR_FLAGS = 8'h24;
  localparam logic [7:0] OP_ENABLE = 8'h19;
  localparam logic [7:0] OP_DISABLE = 8'h1A;
  localparam logic [7:0] OP_DEFINE = 8'h25;
  localparam logic [7:0] OP_RETURN = 8'h26;
  localparam logic [7:0] IRQ_GLOBAL = 8'hFF;
  // flag-clear selectors
  localparam logic [7:0] CLR_ALL = 8'h00;
  localparam logic [7:0] CLR_TIMEOUT = 8'h01;
  localparam logic [7:0] CLR_ALARM = 8'h02;
  localparam logic [7:0] CLR_DEVIATION = 8'h03;
  localparam logic [7:0] CLR_POSITION = 8'h04;
  localparam logic [7:0] CLR_SHUTDOWN = 8'h05;
  // flag bit positions
  localparam int TIMEOUT_FLAG = 0;
  localparam int EXTERNAL_ALARM_FLAG = 1;
  localparam int DEVIATION_FLAG = 2;
  localparam int POSITION_ERROR_FLAG = 3;
  localparam int SHUTDOWN_FLAG = 4;
  // reply status codes
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_CSUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_BAD_MODE = 8'h05;
  // register byte offsets
  localparam logic [5:0] OFS_HEAD = 6'h00;
  localparam logic [5:0] OFS_VALUE = 6'h04;
  localparam logic [5:0] OFS_CSUM = 6'h08;
  localparam logic [5:0] OFS_CTRL = 6'h0C;
  localparam logic [5:0] OFS_REPLY = 6'h10;
  localparam logic [5:0] OFS_FLAGS = 6'h14;
  localparam logic [5:0] OFS_ENABLE = 6'h18;
  localparam logic [5:0] OFS_EVENT = 6'h1C;
  localparam logic [5:0] OFS_MASK = 6'h20;
  // event bit positions
  localparam int EV_DONE = 0;
  localparam int EV_CSUM = 1;
  localparam int EV_REFUSED = 2;
  localparam int EV_ENTER = 3;
  localparam int EV_RETURN = 4;
  // control field positions and reset values
  localparam int CTRL_STANDALONE = 0;
  localparam int CTRL_GLOBAL = 1;
  localparam int CTRL_ADDR_LSB = 8;
  localparam logic [7:0] MODULE_ADDR_RST = 8'h01;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } av_req_s;

  typedef struct packed {
    logic [7:0] target;
    logic [7:0] instr;
    logic [7:0] kind;
    logic [7:0] bank;
    logic [31:0] value;
    logic [7:0] csum;
  } frame_s;

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] x;
    logic [7:0] flags;
    logic [31:0] pc;
  } ctx_s;

  typedef struct packed {
    logic valid;
    logic [7:0] instr;
    logic [7:0] status;
  } reply_s;
endpackage

// ---- design/irq_cmd_core.sv ----
// command interpreter slice: error-flag clear, interrupt enables, vectors, return
//
// How it works
// - instruction 36 clears the error flags chosen by the type byte only
// - type 0 clears all, 1..5 timeout, alarm, deviation, position, shutdown
// - instruction 25 enables the interrupt numbered by the type byte
// - enable with number 255 sets the global interrupt processing enable
// - instruction 26 disables the interrupt numbered by the type byte
// - disable with number 255 clears the global enable, stopping handler entry for all numbered interrupts (irq_o still follows events)
// - instruction 37 stores the value as handler address for the numbered interrupt
// - a later definition for the same number overwrites the stored address
// - instruction 38 restores accumulator, X, flags and counter, then resumes
// - define and return are accepted only in standalone mode
// - frame is address, instruction, type, bank, value msb first, checksum
`timescale 1ns/1ps
module irq_cmd_core (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire irq_cmd_pkg::av_req_s av_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o,
  input wire logic [irq_cmd_pkg::NFLAG-1:0] flag_set_i,
  input wire logic [irq_cmd_pkg::IRQ_N-1:0] irq_src_i,
  input wire irq_cmd_pkg::ctx_s ctx_i,
  output logic [irq_cmd_pkg::NFLAG-1:0] error_flags_o,
  output logic jump_o,
  output logic [31:0] jump_pc_o,
  output logic restore_o,
  output irq_cmd_pkg::ctx_s restore_ctx_o,
  output logic irq_o
);
  import irq_cmd_pkg::*;

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    frame_s frame;
    logic standalone;
    logic [7:0] module_addr;
    reply_s reply;
    logic [NFLAG-1:0] flags;
    logic [IRQ_N-1:0] ien;
    logic gen;
    logic [IRQ_N-1:0] pend;
    logic [NEV-1:0] events;
    logic [NEV-1:0] mask;
    logic in_handler;
    ctx_s saved;
    logic jump;
    logic [31:0] jump_pc;
    logic restore;
    logic irq;
  } state_s;

  state_s st;
  state_s next_st;
  logic [31:0] vec [IRQ_N];
  logic vec_we;
  logic [4:0] vec_idx;
  logic [31:0] vec_data;

  // byte sum of the eight bytes ahead of the checksum
  function automatic logic [7:0] frame_sum(input frame_s f);
    frame_sum = f.target + f.instr + f.kind + f.bank + f.value[31:24] + f.value[23:16]
      + f.value[15:8] + f.value[7:0];
  endfunction

  // flag-clear selector to bit mask; unknown selectors clear nothing
  function automatic logic [NFLAG-1:0] clear_mask(input logic [7:0] kind);
    clear_mask = '0;
    case (kind)
      CLR_ALL: clear_mask = '1;
      CLR_TIMEOUT: clear_mask[TIMEOUT_FLAG] = 1'b1;
      CLR_ALARM: clear_mask[EXTERNAL_ALARM_FLAG] = 1'b1;
      CLR_DEVIATION: clear_mask[DEVIATION_FLAG] = 1'b1;
      CLR_POSITION: clear_mask[POSITION_ERROR_FLAG] = 1'b1;
      CLR_SHUTDOWN: clear_mask[SHUTDOWN_FLAG] = 1'b1;
      default: clear_mask = '0;
    endcase
  endfunction

  function automatic logic irq_in_range(input logic [7:0] n);
    irq_in_range = (n < 8'(IRQ_N));
  endfunction

  always_comb begin
    logic done;
    logic wr;
    logic rd;
    logic exec;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] ev_clr;
    logic [NFLAG-1:0] fl_clr;
    logic [IRQ_N-1:0] pend_clr;
    logic [IRQ_N-1:0] ready;
    logic [7:0] status;
    logic send;
    logic found;
    logic [4:0] pick;
    done = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    exec = 1'b0;
    ev = '0;
    ev_clr = '0;
    fl_clr = '0;
    pend_clr = '0;
    ready = '0;
    status = ST_OK;
    send = 1'b0;
    found = 1'b0;
    pick = '0;
    vec_we = 1'b0;
    vec_idx = st.frame.kind[4:0];
    vec_data = st.frame.value;
    next_st = st;
    next_st.jump = 1'b0;
    next_st.restore = 1'b0;

    // one wait cycle, then the access completes at the edge with waitrequest low
    done = (av_i.read || av_i.write) && !st.wreq;
    wr = done && av_i.write;
    rd = done && av_i.read;
    next_st.wreq = !((av_i.read || av_i.write) && st.wreq);
    if ((av_i.read || av_i.write) && st.wreq) begin
      case (av_i.address)
        OFS_HEAD: next_st.rdata = {st.frame.target, st.frame.instr, st.frame.kind, st.frame.bank};
        OFS_VALUE: next_st.rdata = st.frame.value;
        OFS_CSUM: next_st.rdata = {24'h000000, st.frame.csum};
        OFS_CTRL: next_st.rdata = {16'h0000, st.module_addr, 6'h00, st.gen, st.standalone};
        OFS_REPLY: next_st.rdata = {15'h0000, st.reply};
        OFS_FLAGS: next_st.rdata = {27'h0000000, st.flags};
        OFS_ENABLE: next_st.rdata = st.ien;
        OFS_EVENT: next_st.rdata = {27'h0000000, st.events};
        OFS_MASK: next_st.rdata = {27'h0000000, st.mask};
        default: next_st.rdata = 32'h00000000;
      endcase
    end

    if (wr) begin
      case (av_i.address)
        OFS_HEAD: begin
          {next_st.frame.target, next_st.frame.instr} = av_i.writedata[31:16];
          {next_st.frame.kind, next_st.frame.bank} = av_i.writedata[15:0];
        end
        OFS_VALUE: next_st.frame.value = av_i.writedata;
        OFS_CSUM: begin
          next_st.frame.csum = av_i.writedata[7:0];
          exec = 1'b1;
        end
        OFS_CTRL: begin
          next_st.standalone = av_i.writedata[CTRL_STANDALONE];
          next_st.module_addr = av_i.writedata[CTRL_ADDR_LSB +: 8];
        end
        OFS_MASK: next_st.mask = av_i.writedata[NEV-1:0];
        default: ;
      endcase
    end
    if (rd && av_i.address == OFS_REPLY) begin
      next_st.reply.valid = 1'b0;
    end
    if (rd && av_i.address == OFS_EVENT) begin
      ev_clr = '1;
    end

    // frames for another module with a good checksum are dropped without a reply
    if (exec && av_i.writedata[7:0] != frame_sum(st.frame)) begin
      status = ST_BAD_CSUM;
      ev[EV_CSUM] = 1'b1;
      send = 1'b1;
    end else if (exec && st.frame.target != st.module_addr) begin
      ev[EV_REFUSED] = 1'b1;
    end else if (exec) begin
      send = 1'b1;
      case (st.frame.instr)
        OP_CLEAR_FLAGS: begin
          if (st.frame.kind > CLR_SHUTDOWN) begin
            status = ST_BAD_VALUE;
          end
          fl_clr = clear_mask(st.frame.kind);
        end
        OP_ENABLE: begin
          if (st.frame.kind == IRQ_GLOBAL) begin
            next_st.gen = 1'b1;
          end else if (irq_in_range(st.frame.kind)) begin
            next_st.ien[st.frame.kind[4:0]] = 1'b1;
          end else begin
            status = ST_BAD_VALUE;
          end
        end
        OP_DISABLE: begin
          if (st.frame.kind == IRQ_GLOBAL) begin
            next_st.gen = 1'b0;
          end else if (irq_in_range(st.frame.kind)) begin
            next_st.ien[st.frame.kind[4:0]] = 1'b0;
          end else begin
            status = ST_BAD_VALUE;
          end
        end
        OP_DEFINE: begin
          if (!st.standalone) begin
            status = ST_BAD_MODE;
          end else if (irq_in_range(st.frame.kind)) begin
            vec_we = 1'b1;
          end else begin
            status = ST_BAD_VALUE;
          end
        end
        OP_RETURN: begin
          if (!st.standalone || !st.in_handler) begin
            status = ST_BAD_MODE;
          end else begin
            next_st.restore = 1'b1;
            next_st.saved = st.saved;
            next_st.in_handler = 1'b0;
            ev[EV_RETURN] = 1'b1;
          end
        end
        default: status = ST_BAD_CMD;
      endcase
      if (status != ST_OK) begin
        ev[EV_REFUSED] = 1'b1;
      end else begin
        ev[EV_DONE] = 1'b1;
      end
    end
    // stored programs get no reply frame
    if (send && !st.standalone) begin
      next_st.reply = '{valid: 1'b1, instr: st.frame.instr, status: status};
    end

    // lowest-numbered ready source wins; entry waits while a command executes
    ready = st.pend & st.ien;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (ready[i]) begin
        found = 1'b1;
        pick = 5'(i);
      end
    end
    if (!exec && st.standalone && st.gen && !st.in_handler && found) begin
      next_st.saved = ctx_i;
      next_st.jump = 1'b1;
      next_st.jump_pc = vec[pick];
      next_st.in_handler = 1'b1;
      pend_clr[pick] = 1'b1;
      ev[EV_ENTER] = 1'b1;
    end

    // a new set in the clearing cycle wins over the clear
    next_st.pend = (st.pend & ~pend_clr) | irq_src_i;
    next_st.flags = (st.flags & ~fl_clr) | flag_set_i;
    next_st.events = (st.events & ~ev_clr) | ev;
    next_st.irq = |(next_st.events & next_st.mask);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.wreq <= 1'b1;
      st.module_addr <= MODULE_ADDR_RST;
    end else begin
      st <= next_st;
    end
  end

  // vectors reset to zero so an undefined handler jumps to address zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < IRQ_N; i++) begin
        vec[i] <= 32'h00000000;
      end
    end else if (vec_we) begin
      vec[vec_idx] <= vec_data;
    end
  end

  assign av_readdata_o = st.rdata;
  assign av_waitrequest_o = st.wreq;
  assign error_flags_o = st.flags;
  assign jump_o = st.jump;
  assign jump_pc_o = st.jump_pc;
  assign restore_o = st.restore;
  assign restore_ctx_o = st.saved;
  assign irq_o = st.irq;
endmodule

// ---- test/irq_cmd_monitor.sv ----
// assertion checker for the command block ports
`timescale 1ns/1ps
module irq_cmd_monitor
  import irq_cmd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire irq_cmd_pkg::av_req_s av_i,
  input wire logic [31:0] av_readdata_o,
  input wire logic av_waitrequest_o,
  input wire logic [irq_cmd_pkg::NFLAG-1:0] flag_set_i,
  input wire logic [irq_cmd_pkg::IRQ_N-1:0] irq_src_i,
  input wire irq_cmd_pkg::ctx_s ctx_i,
  input wire logic [irq_cmd_pkg::NFLAG-1:0] error_flags_o,
  input wire logic jump_o,
  input wire logic [31:0] jump_pc_o,
  input wire logic restore_o,
  input wire irq_cmd_pkg::ctx_s restore_ctx_o,
  input wire logic irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_wait_once: assert property ((av_i.read || av_i.write) && av_waitrequest_o |=>
    !av_waitrequest_o) else $error("access not answered after one wait");
  a_wait_cause: assert property (!av_waitrequest_o |->
    $past(av_i.read || av_i.write)) else $error("answer without request");
  a_wait_short: assert property (!av_waitrequest_o |=> av_waitrequest_o)
    else $error("answer longer than one cycle");
  a_jump_pulse: assert property (jump_o |=> !jump_o) else $error("jump too long");
  a_restore_pulse: assert property (restore_o |=> !restore_o)
    else $error("restore too long");
  a_flag_set: assert property (|flag_set_i |=>
    (error_flags_o & $past(flag_set_i)) == $past(flag_set_i)) else $error("flag not set");
  a_flag_hold: assert property (!(av_i.write && !av_waitrequest_o) |=>
    ($past(error_flags_o) & ~error_flags_o) == '0) else $error("flag lost without command");
  a_entry_ctx: assert property (jump_o |-> restore_ctx_o == $past(ctx_i))
    else $error("context not saved at entry");
endmodule

// ---- test/irq_cmd_prog.sv ----
// program-side model: runs the context, follows jumps and returns
`timescale 1ns/1ps
module irq_cmd_prog
  import irq_cmd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic jump_i,
  input wire logic [31:0] jump_pc_i,
  input wire logic restore_i,
  input wire irq_cmd_pkg::ctx_s restore_ctx_i,
  output irq_cmd_pkg::ctx_s ctx_o
);
  initial ctx_o = '0;
  // handler code is entered only by a jump and always left by a return
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctx_o <= '0;
    end else if (jump_i) begin
      ctx_o.pc <= jump_pc_i;
    end else if (restore_i) begin
      ctx_o <= restore_ctx_i;
    end else begin
      ctx_o.pc <= ctx_o.pc + 32'h1;
      ctx_o.acc <= ctx_o.acc + 32'h3;
    end
  end
endmodule

// ---- test/tb.sv ----
// self-checking testbench of the command block
`timescale 1ns/1ps
module tb;
  import irq_cmd_pkg::*;
  logic ref_clk_i;
  logic rst_n_i = 0;
  av_req_s av = '0;
  logic [4:0] fset = '0;
  logic [31:0] src = '0;
  logic [31:0] rdata, jpc, seed = 32'h38;
  logic wt, jmp, rsto, irq;
  logic [4:0] flags;
  ctx_s ctx, rctx;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] rq[$], jq[$], xq[$];
  logic [31:0] last_pc;
  initial begin
    ref_clk_i = 0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  irq_cmd_core i_irq_cmd_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .av_i(av),
    .av_readdata_o(rdata), .av_waitrequest_o(wt), .flag_set_i(fset), .irq_src_i(src),
    .ctx_i(ctx), .error_flags_o(flags), .jump_o(jmp), .jump_pc_o(jpc), .restore_o(rsto),
    .restore_ctx_o(rctx), .irq_o(irq));
  irq_cmd_prog i_irq_cmd_prog (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .jump_i(jmp),
    .jump_pc_i(jpc), .restore_i(rsto), .restore_ctx_i(rctx), .ctx_o(ctx));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic mism(input string n, input logic [31:0] e, input logic [31:0] s);
    err_count++;
    $display("ERROR %s expected %h seen %h", n, e, s);
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic take(ref logic [31:0] q[$], input string n, input logic [31:0] s);
    checks_done++;
    if (q.size() == 0) begin
      mism(n, 32'h0, s);
    end else if (s !== q[0]) begin
      mism(n, q[0], s);
    end
    if (q.size() != 0) void'(q.pop_front());
  endtask
  // outputs are taken at the edge where they stand, before that edge updates them
  // the saved pc must be the model's pc seen at the edge before the jump pulse
  always @(posedge ref_clk_i) begin
    if (av.read && !wt) take(rq, "readdata", rdata);
    if (jmp === 1'b1) take(jq, "jump_pc_o", jpc);
    if (jmp === 1'b1) xq.push_back(last_pc);
    if (rsto === 1'b1) take(xq, "restore_ctx_o", rctx.pc);
    last_pc = ctx.pc;
  end
  task automatic acc(input logic rd, input logic [5:0] a, input logic [31:0] d);
    av <= '{rd, !rd, a, d};
    do @(posedge ref_clk_i); while (wt !== 1'b0);
    av <= '0;
    @(posedge ref_clk_i);
  endtask
  task automatic chk(input logic [5:0] a, input logic [31:0] e);
    rq.push_back(e);
    acc(1'b1, a, 32'h0);
  endtask
  task automatic frame(input logic [7:0] t, i, k, input logic [31:0] v, input logic [7:0] bad);
    acc(1'b0, OFS_HEAD, {t, i, k, 8'h00});
    acc(1'b0, OFS_VALUE, v);
    acc(1'b0, OFS_CSUM, {24'h0, 8'(t + i + k + v[31:24] + v[23:16] + v[15:8] + v[7:0] + bad)});
  endtask
  function logic [31:0] rep(input logic [7:0] i, input logic [7:0] s);
    return {15'h0, 1'b1, i, s};
  endfunction
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    finish_test();
  end
  initial begin
    logic [7:0] n;
    logic [31:0] em, v;
    logic [4:0] f;
    em = '0;
    f = 5'h1F;
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1;
    chk(OFS_CTRL, 32'h100);
    chk(6'h3C, 32'h0);
    fset <= 5'h1F;
    @(posedge ref_clk_i);
    fset <= '0;
    chk(OFS_FLAGS, 32'h1F);
    for (int k = 1; k <= 5; k++) begin
      frame(8'h01, OP_CLEAR_FLAGS, 8'(k), rnd(), 8'h00);
      f[k-1] = 1'b0;
      chk(OFS_FLAGS, {27'h0, f});
      checks_done++;
      if (flags !== f) mism("error_flags_o", {27'h0, f}, {27'h0, flags});
      chk(OFS_REPLY, rep(OP_CLEAR_FLAGS, ST_OK));
    end
    fset <= 5'h15;
    @(posedge ref_clk_i);
    fset <= '0;
    frame(8'h01, OP_CLEAR_FLAGS, 8'h06, 32'h0, 8'h00);
    chk(OFS_FLAGS, 32'h15);
    frame(8'h01, OP_CLEAR_FLAGS, CLR_ALL, 32'h0, 8'h00);
    chk(OFS_FLAGS, 32'h0);
    frame(8'h01, OP_ENABLE, 8'h00, 32'h0, 8'h01);
    chk(OFS_REPLY, rep(OP_ENABLE, ST_BAD_CSUM));
    for (int j = 0; j < 4; j++) begin
      n = 8'(rnd() & 32'h1F);
      frame(8'h01, OP_ENABLE, n, 32'h0, 8'h00);
      em[n[4:0]] = 1'b1;
      chk(OFS_ENABLE, em);
    end
    frame(8'h01, OP_DISABLE, n, 32'h0, 8'h00);
    em[n[4:0]] = 1'b0;
    chk(OFS_ENABLE, em);
    frame(8'h01, OP_ENABLE, IRQ_GLOBAL, 32'h0, 8'h00);
    chk(OFS_CTRL, 32'h102);
    frame(8'h01, OP_DISABLE, IRQ_GLOBAL, 32'h0, 8'h00);
    chk(OFS_CTRL, 32'h100);
    frame(8'h01, OP_DEFINE, 8'h03, 32'h0, 8'h00);
    chk(OFS_REPLY, rep(OP_DEFINE, ST_BAD_MODE));
    frame(8'h02, OP_ENABLE, 8'h00, 32'h0, 8'h00);
    chk(OFS_REPLY, {16'h0, OP_DEFINE, ST_BAD_MODE});
    chk(OFS_EVENT, 32'h07);
    acc(1'b0, OFS_CTRL, 32'h101);
    v = rnd();
    frame(8'h01, OP_DEFINE, 8'h03, ~v, 8'h00);
    frame(8'h01, OP_DEFINE, 8'h03, v, 8'h00);
    frame(8'h01, OP_ENABLE, 8'h03, 32'h0, 8'h00);
    frame(8'h01, OP_ENABLE, IRQ_GLOBAL, 32'h0, 8'h00);
    acc(1'b0, OFS_MASK, 32'h08);
    chk(OFS_EVENT, 32'h01);
    jq.push_back(v);
    src <= 32'h8;
    @(posedge ref_clk_i);
    src <= '0;
    repeat (4) @(posedge ref_clk_i);
    checks_done++;
    if (irq !== 1'b1) mism("irq_o", 32'h1, {31'h0, irq});
    chk(OFS_EVENT, 32'h08);
    checks_done++;
    if (irq !== 1'b0) mism("irq_o", 32'h0, {31'h0, irq});
    frame(8'h01, OP_RETURN, 8'h00, 32'h0, 8'h00);
    chk(OFS_EVENT, 32'h11);
    checks_done++;
    if (jq.size() != 0) mism("jump_o", 32'h1, 32'h0);
    checks_done++;
    if (xq.size() != 0) mism("restore_o", 32'h1, 32'h0);
    finish_test();
  end
endmodule
bind irq_cmd_core irq_cmd_monitor i_irq_cmd_monitor (.*);
